// File: common/ixe_pkg.sv
/*
  Shared constants and types for the instruction execute subset core:
  register offsets, status flag positions, reset values, operation codes
  and controller states.
  Assumes a single 100 MHz clock domain and an 8-bit data path.
*/
package ixe_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, low half of the register bus address space
  localparam logic [7:0] REG_ACC = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h01;
  localparam logic [7:0] REG_TABLE_POINTER_LOW = 8'h02;
  localparam logic [7:0] REG_TABLE_POINTER_HIGH = 8'h03;
  localparam logic [7:0] REG_TABLE_HIGH_BYTE = 8'h04;
  localparam logic [7:0] REG_SECT = 8'h05;

  ////////////////////////////////////////////////////////////////////////////
  // Status flag bit positions
  localparam int CARRY_FLAG = 0;
  localparam int AUX_CARRY_FLAG = 1;
  localparam int ZERO_FLAG = 2;
  localparam int OVERFLOW_FLAG = 3;
  localparam int SIGNED_ZERO_FLAG = 4;
  localparam int CARRY_ZERO_FLAG = 5;
  localparam logic [7:0] STATUS_MASK = 8'h3F;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and arithmetic constants
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] TBL_RST = 8'h00;
  localparam logic [7:0] MEM_RST = 8'h00;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [7:0] BCD_LOW_ADJ = 8'h06;
  localparam logic [7:0] BCD_HIGH_ADJ = 8'h60;
  localparam int PAGE_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Operation codes; extended operations start at op_ext_add_carry
  typedef enum logic [4:0] {
    op_subtract_to_memory = 5'h00,
    op_subtract_imm = 5'h01,
    op_nibble_exchange = 5'h02,
    op_nibble_exchange_to_acc = 5'h03,
    op_skip_on_zero = 5'h04,
    op_skip_on_zero_move = 5'h05,
    op_skip_on_zero_bit = 5'h06,
    op_paged_table_read = 5'h07,
    op_last_page_table_read = 5'h08,
    op_incr_paged_table_read = 5'h09,
    op_incr_last_page_table_read = 5'h0A,
    op_exclusive_or = 5'h0B,
    op_exclusive_or_to_memory = 5'h0C,
    op_exclusive_or_imm = 5'h0D,
    op_ext_add_carry = 5'h10,
    op_ext_add_carry_to_memory = 5'h11,
    op_ext_add = 5'h12,
    op_ext_add_to_memory = 5'h13,
    op_ext_and = 5'h14,
    op_ext_and_to_memory = 5'h15,
    op_ext_clear = 5'h16,
    op_ext_clear_bit = 5'h17,
    op_ext_invert = 5'h18,
    op_ext_invert_to_acc = 5'h19,
    op_ext_decimal_adjust = 5'h1A
  } ixe_op_t;

  ////////////////////////////////////////////////////////////////////////////
  // Controller states
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_exec = 3'b001,
    st_dummy = 3'b010,
    st_tfetch = 3'b011,
    st_tload = 3'b100
  } ixe_state_t;

endpackage

// File: design/ixe_core.sv
/*
  Execute unit for a subset of an 8-bit microcontroller instruction set,
  with its own data memory, accumulator, status flags and table pointer.
  Assumes commands, register bus and program memory all run on ref_clk;
  the program memory answers one clock after it samples prog_addr.
*/
`timescale 1ns/100ps
`default_nettype none

module ixe_core #(
  parameter int DM_SECTIONS = 2,
  parameter int PROG_AW = 12,
  localparam int SECT_W = $clog2(DM_SECTIONS),
  localparam int BUS_AW = SECT_W + 9
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Command port
  input wire logic cmd_valid,
  input wire ixe_pkg::ixe_op_t cmd_op,
  input wire logic [7:0] cmd_offset,
  input wire logic [SECT_W-1:0] cmd_section,
  input wire logic [7:0] cmd_imm,
  input wire logic [2:0] cmd_bit,
  output logic busy,
  output logic done,
  output logic skipped,
  // Program memory port
  output logic [PROG_AW-1:0] prog_addr,
  output logic prog_rd,
  input wire logic [15:0] prog_data,
  // Register bus
  input wire logic [BUS_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  import ixe_pkg::*;

  localparam int DM_BYTES = DM_SECTIONS * 256;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks
  if (DM_SECTIONS < 2 || DM_SECTIONS > 8 ||
      (1 << SECT_W) != DM_SECTIONS) begin : g_bad_sections
    $error("DM_SECTIONS must be a power of two from 2 to 8");
  end
  if (PROG_AW < 9 || PROG_AW > 16) begin : g_bad_prog_aw
    $error("PROG_AW must lie between 9 and 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    ixe_state_t st;
    logic busy;
    logic done;
    logic skipped;
    logic prog_rd;
    logic [PROG_AW-1:0] prog_addr;
    logic [7:0] rdata;
    logic [7:0] acc;
    logic [7:0] status;
    logic [7:0] table_pointer_low;
    logic [7:0] table_pointer_high;
    logic [7:0] table_high_byte_reg;
    logic [SECT_W-1:0] sect;
    ixe_op_t op;
    logic [7:0] off;
    logic [SECT_W-1:0] xsect;
    logic [7:0] imm;
    logic [2:0] bsel;
    logic [DM_BYTES-1:0][7:0] mem;
  } ixe_core_state_t;

  ixe_core_state_t r;
  ixe_core_state_t next_r;

  ////////////////////////////////////////////////////////////////////////////
  // Adder: {overflow, nibble carry, carry, sum}
  function automatic logic [10:0] alu_add(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input logic ci);
    logic [4:0] lo;
    logic [8:0] s;
    logic ov;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    ov = (a[7] == b[7]) && (s[7] != a[7]);
    return {ov, lo[4], s[8], s[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Combinational working signals
  logic is_ext;
  logic [SECT_W+7:0] ea;
  logic [7:0] m;
  logic [7:0] opnd;
  logic is_sub;
  logic is_adc;
  logic [10:0] alu;
  logic [7:0] res;
  logic lo_adj;
  logic hi_adj;
  logic [8:0] bcd;
  logic [7:0] tp;
  logic [15:0] page_addr;
  logic [SECT_W+7:0] bus_idx;

  always_comb begin
    next_r = r;
    is_ext = r.op >= op_ext_add_carry;
    ea = {is_ext ? r.xsect : r.sect, r.off};
    m = r.mem[ea];
    opnd = (r.op == op_subtract_imm) ? r.imm : m;
    is_sub = (r.op == op_subtract_to_memory) || (r.op == op_subtract_imm);
    is_adc = (r.op == op_ext_add_carry) ||
             (r.op == op_ext_add_carry_to_memory);
    alu = alu_add(r.acc, is_sub ? ~opnd : opnd,
                  is_sub | (is_adc & r.status[CARRY_FLAG]));
    res = 8'h00;
    lo_adj = (r.acc[3:0] > BCD_MAX) | r.status[AUX_CARRY_FLAG];
    hi_adj = (r.acc[7:4] > BCD_MAX) | r.status[CARRY_FLAG];
    bcd = {1'b0, r.acc} + {1'b0, lo_adj ? BCD_LOW_ADJ : 8'h00} +
          {1'b0, hi_adj ? BCD_HIGH_ADJ : 8'h00};
    tp = r.table_pointer_low + 8'h01;
    if (r.op == op_paged_table_read || r.op == op_last_page_table_read) begin
      tp = r.table_pointer_low;
    end
    page_addr = {r.table_pointer_high, tp};
    bus_idx = reg_addr[SECT_W+7:0];
    next_r.done = 1'b0;
    next_r.skipped = 1'b0;
    next_r.prog_rd = 1'b0;

    // Register bus read, valid in the following cycle only
    next_r.rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr[BUS_AW-1]) begin
        next_r.rdata = r.mem[bus_idx];
      end else begin
        unique case (reg_addr[7:0])
          REG_ACC: next_r.rdata = r.acc;
          REG_STATUS: next_r.rdata = r.status & STATUS_MASK;
          REG_TABLE_POINTER_LOW: next_r.rdata = r.table_pointer_low;
          REG_TABLE_POINTER_HIGH: next_r.rdata = r.table_pointer_high;
          REG_TABLE_HIGH_BYTE: next_r.rdata = r.table_high_byte_reg;
          REG_SECT: next_r.rdata = {{(8-SECT_W){1'b0}}, r.sect};
          default: next_r.rdata = 8'h00;
        endcase
      end
    end

    // Register bus write; core updates below take precedence
    if (reg_wr) begin
      if (reg_addr[BUS_AW-1]) begin
        next_r.mem[bus_idx] = reg_wdata;
      end else begin
        unique case (reg_addr[7:0])
          REG_ACC: next_r.acc = reg_wdata;
          REG_STATUS: next_r.status = reg_wdata & STATUS_MASK;
          REG_TABLE_POINTER_LOW: next_r.table_pointer_low = reg_wdata;
          REG_TABLE_POINTER_HIGH: next_r.table_pointer_high = reg_wdata;
          REG_TABLE_HIGH_BYTE: next_r.table_high_byte_reg = reg_wdata;
          REG_SECT: next_r.sect = reg_wdata[SECT_W-1:0];
          default: next_r.sect = next_r.sect;
        endcase
      end
    end

    unique case (r.st)
      st_idle: begin
        if (cmd_valid) begin
          next_r.st = st_exec;
          next_r.busy = 1'b1;
          next_r.op = cmd_op;
          next_r.off = cmd_offset;
          next_r.xsect = cmd_section;
          next_r.imm = cmd_imm;
          next_r.bsel = cmd_bit;
        end
      end
      st_exec: begin
        next_r.st = st_idle;
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
        case (r.op)
          op_subtract_to_memory: next_r.mem[ea] = alu[7:0];
          op_subtract_imm: next_r.acc = alu[7:0];
          op_nibble_exchange: next_r.mem[ea] = {m[3:0], m[7:4]};
          op_nibble_exchange_to_acc: next_r.acc = {m[3:0], m[7:4]};
          op_skip_on_zero: begin
            next_r.mem[ea] = m;
            if (m == 8'h00) begin
              next_r.st = st_dummy;
            end
          end
          op_skip_on_zero_move: begin
            next_r.acc = m;
            if (m == 8'h00) begin
              next_r.st = st_dummy;
            end
          end
          op_skip_on_zero_bit: begin
            if (!m[r.bsel]) begin
              next_r.st = st_dummy;
            end
          end
          op_paged_table_read, op_incr_paged_table_read,
          op_last_page_table_read, op_incr_last_page_table_read: begin
            next_r.table_pointer_low = tp;
            next_r.st = st_tfetch;
            next_r.prog_rd = 1'b1;
            next_r.prog_addr = page_addr[PROG_AW-1:0];
            if (r.op == op_last_page_table_read ||
                r.op == op_incr_last_page_table_read) begin
              next_r.prog_addr = {{(PROG_AW-PAGE_W){1'b1}}, tp};
            end
          end
          op_exclusive_or: res = r.acc ^ m;
          op_exclusive_or_imm: res = r.acc ^ r.imm;
          op_exclusive_or_to_memory: begin
            res = r.acc ^ m;
            next_r.mem[ea] = res;
          end
          op_ext_add_carry, op_ext_add: next_r.acc = alu[7:0];
          op_ext_add_carry_to_memory, op_ext_add_to_memory: begin
            next_r.mem[ea] = alu[7:0];
          end
          op_ext_and: res = r.acc & m;
          op_ext_and_to_memory: begin
            res = r.acc & m;
            next_r.mem[ea] = res;
          end
          op_ext_clear: next_r.mem[ea] = 8'h00;
          op_ext_clear_bit: next_r.mem[ea][r.bsel] = 1'b0;
          op_ext_invert: begin
            res = ~m;
            next_r.mem[ea] = res;
          end
          op_ext_invert_to_acc: res = ~m;
          op_ext_decimal_adjust: begin
            next_r.mem[ea] = bcd[7:0];
            next_r.status[CARRY_FLAG] = r.status[CARRY_FLAG] | bcd[8] |
                                        (r.acc[7:4] > BCD_MAX);
          end
          default: next_r.done = 1'b1;
        endcase
        if (r.op == op_exclusive_or || r.op == op_exclusive_or_imm ||
            r.op == op_ext_and || r.op == op_ext_invert_to_acc) begin
          next_r.acc = res;
        end
        if (r.op == op_exclusive_or || r.op == op_exclusive_or_imm ||
            r.op == op_exclusive_or_to_memory || r.op == op_ext_and ||
            r.op == op_ext_and_to_memory || r.op == op_ext_invert ||
            r.op == op_ext_invert_to_acc) begin
          next_r.status[ZERO_FLAG] = (res == 8'h00);
        end
        if (is_sub || (r.op >= op_ext_add_carry &&
                       r.op <= op_ext_add_to_memory)) begin
          next_r.status[OVERFLOW_FLAG] = alu[10];
          next_r.status[AUX_CARRY_FLAG] = alu[9];
          next_r.status[CARRY_FLAG] = alu[8];
          next_r.status[ZERO_FLAG] = (alu[7:0] == 8'h00);
          next_r.status[SIGNED_ZERO_FLAG] = alu[10] ^ alu[7];
          if (is_sub) begin
            next_r.status[CARRY_ZERO_FLAG] = (alu[7:0] == 8'h00);
          end
        end
        if (next_r.st != st_idle) begin
          next_r.busy = 1'b1;
          next_r.done = 1'b0;
        end
      end
      // dummy cycle on a taken skip
      st_dummy: begin
        next_r.st = st_idle;
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
        next_r.skipped = 1'b1;
      end
      st_tfetch: next_r.st = st_tload;
      st_tload: begin
        next_r.mem[ea] = prog_data[7:0];
        next_r.table_high_byte_reg = prog_data[15:8];
        next_r.st = st_idle;
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end
      default: begin
        next_r.st = st_idle;
        next_r.busy = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
      r.st <= st_idle;
      r.op <= op_subtract_to_memory;
      r.acc <= ACC_RST;
      r.status <= STATUS_RST;
      r.table_pointer_low <= TBL_RST;
      r.table_pointer_high <= TBL_RST;
      r.table_high_byte_reg <= TBL_RST;
      r.mem <= {DM_BYTES{MEM_RST}};
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign busy = r.busy;
  assign done = r.done;
  assign skipped = r.skipped;
  assign prog_addr = r.prog_addr;
  assign prog_rd = r.prog_rd;
  assign reg_rdata = r.rdata;

endmodule

`default_nettype wire

// File: bench/ixe_core_sva.sv
/*
  Port-level checker for the execute core: command timing, skip cycles,
  table fetch timing and program address forming.
  Assumes one clock domain and attachment by bind from the testbench.
*/
`timescale 1ns/100ps
`default_nettype none

module ixe_core_sva
  import ixe_pkg::*;
#(
  parameter int PROG_AW = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Command port
  input wire logic cmd_valid,
  input wire ixe_pkg::ixe_op_t cmd_op,
  input wire logic busy,
  input wire logic done,
  input wire logic skipped,
  // Program memory port
  input wire logic [PROG_AW-1:0] prog_addr,
  input wire logic prog_rd
);
  ixe_op_t cur_op;
  logic take;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Operation in progress
  assign take = cmd_valid && !busy;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_op <= op_subtract_to_memory;
    end else if (take) begin
      cur_op <= cmd_op;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_skip_dummy;
    skipped |-> $past(busy) && $past(busy, 2) && !busy;
  endproperty
  a_skip_dummy: assert property (p_skip_dummy)
    else $error("skip without dummy cycle");
  property p_skip_done;
    skipped |-> done;
  endproperty
  a_skip_done: assert property (p_skip_done)
    else $error("skip flag outside done");
  property p_skip_kind;
    skipped |-> cur_op inside {op_skip_on_zero, op_skip_on_zero_move,
      op_skip_on_zero_bit};
  endproperty
  a_skip_kind: assert property (p_skip_kind)
    else $error("skip from non-skip op");
  property p_done_pulse;
    done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done longer than one cycle");
  property p_plain;
    take && cmd_op == op_subtract_imm |=> busy ##1 (done && !skipped && !busy);
  endproperty
  a_plain: assert property (p_plain)
    else $error("subtract immediate timing");
  property p_tbl_start;
    take && cmd_op inside {op_paged_table_read, op_last_page_table_read,
      op_incr_paged_table_read, op_incr_last_page_table_read}
      |=> busy ##1 prog_rd;
  endproperty
  a_tbl_start: assert property (p_tbl_start)
    else $error("table read fetch missing");
  property p_tbl_done;
    prog_rd |-> ##2 (done && !skipped);
  endproperty
  a_tbl_done: assert property (p_tbl_done)
    else $error("table read done timing");
  property p_tbl_hold;
    prog_rd |=> $stable(prog_addr) [*3];
  endproperty
  a_tbl_hold: assert property (p_tbl_hold)
    else $error("program address moved");
  property p_last_page;
    prog_rd && cur_op inside {op_last_page_table_read,
      op_incr_last_page_table_read} |-> &prog_addr[PROG_AW-1:8];
  endproperty
  a_last_page: assert property (p_last_page)
    else $error("last page address wrong");

  c_skip: cover property (skipped);
  c_fetch: cover property (prog_rd);
  c_refused: cover property (cmd_valid && busy);
endmodule

`default_nettype wire

// File: bench/ixe_core_test.sv
/*
  Self-checking testbench for the execute core: table of operations,
  reset values, back-to-back commands and table reads.
  Assumes the package, the core and its checker are built together with it.
*/
`timescale 1ns/100ps
`default_nettype none

module ixe_core_test;
  import ixe_pkg::*;
  typedef struct {ixe_op_t op; logic [63:0] v;} ixe_row_t;

  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  ixe_op_t cmd_op = op_subtract_to_memory;
  logic [7:0] cmd_offset = 8'h10;
  logic [0:0] cmd_section = 1'b0;
  logic [7:0] cmd_imm = 8'h00;
  logic [2:0] cmd_bit = 3'h0;
  logic busy, done, skipped, prog_rd;
  logic [11:0] prog_addr;
  logic [15:0] prog_data = 16'h0000;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  int error_cnt = 0;
  int n_compared = 0;
  ixe_op_t tops[4] = '{op_paged_table_read, op_last_page_table_read,
    op_incr_paged_table_read, op_incr_last_page_table_read};
  // Fields: acc, mem, status, imm, exp acc, exp mem, exp status, skip
  ixe_row_t rows[28] = '{
    '{op_subtract_to_memory, 64'h0503_0000_0502_0300},
    '{op_subtract_imm, 64'h0300_0005_FE00_1000},
    '{op_subtract_imm, 64'h8000_0001_7F00_1900},
    '{op_subtract_imm, 64'h4200_0042_0000_2700},
    '{op_nibble_exchange, 64'h11A5_3F00_115A_3F00},
    '{op_nibble_exchange_to_acc, 64'h003C_1500_C33C_1500},
    '{op_skip_on_zero, 64'h5500_0000_5500_0001},
    '{op_skip_on_zero, 64'h5501_0000_5501_0000},
    '{op_skip_on_zero_move, 64'hFF00_0000_0000_0001},
    '{op_skip_on_zero_move, 64'h007E_0000_7E7E_0000},
    '{op_skip_on_zero_bit, 64'hAAF7_0003_AAF7_0001},
    '{op_skip_on_zero_bit, 64'hAA08_0003_AA08_0000},
    '{op_exclusive_or, 64'h0FFF_3F00_F0FF_3B00},
    '{op_exclusive_or_to_memory, 64'h5A5A_0000_5A00_0400},
    '{op_exclusive_or_imm, 64'h3300_0033_0000_0400},
    '{op_ext_add_carry, 64'h7F00_2100_8000_2A00},
    '{op_ext_add_carry_to_memory, 64'hFF01_0000_FF00_0700},
    '{op_ext_add, 64'h8080_0100_0080_1D00},
    '{op_ext_add_to_memory, 64'h1234_2000_1246_2000},
    '{op_ext_and, 64'hF00F_0000_000F_0400},
    '{op_ext_and_to_memory, 64'h3CF0_3F00_3C30_3B00},
    '{op_ext_clear, 64'h00AA_3F00_0000_3F00},
    '{op_ext_clear_bit, 64'h00FF_3F07_007F_3F00},
    '{op_ext_invert, 64'h00FF_0000_0000_0400},
    '{op_ext_invert_to_acc, 64'h005A_0400_A55A_0000},
    '{op_ext_decimal_adjust, 64'h1B00_0000_1B21_0000},
    '{op_ext_decimal_adjust, 64'hA300_0200_A309_0300},
    '{op_ext_decimal_adjust, 64'h0000_0300_0066_0300}};

  always #5 ref_clk = ~ref_clk;

  // Program memory answers one cycle after the fetch pulse
  always @(posedge ref_clk) begin
    prog_data <= prog_rd ? {4'hA, prog_addr} : ~prog_data;
  end

  ixe_core #(.DM_SECTIONS(2), .PROG_AW(12)) uut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_offset(cmd_offset), .cmd_section(cmd_section),
    .cmd_imm(cmd_imm), .cmd_bit(cmd_bit), .busy(busy), .done(done),
    .skipped(skipped), .prog_addr(prog_addr), .prog_rd(prog_rd),
    .prog_data(prog_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  task automatic chk(input string name, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic run(input ixe_op_t op, input logic [7:0] x,
      output int cyc, output logic sk);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_section <= op[4];
    cmd_imm <= x;
    cmd_bit <= x[2:0];
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    sk = 1'b0;
    for (cyc = 2; cyc < 12; cyc++) begin
      @(posedge ref_clk);
      #1;
      chk("busy", 16'(busy), 16'(done !== 1'b1));
      if (done === 1'b1) begin
        sk = skipped;
        return;
      end
    end
    error_cnt++;
    report_and_stop();
  endtask

  initial begin
    ixe_row_t r;
    logic [7:0] d, tp;
    logic [11:0] pa;
    logic sk;
    int cyc;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd({2'b00, (i == 6) ? 8'h77 : 8'(i)}, d);
      chk("reset", 16'(d), 16'h0000);
    end
    foreach (rows[i]) begin
      r = rows[i];
      wr({2'b00, REG_ACC}, r.v[63:56]);
      wr({2'b00, REG_STATUS}, r.v[47:40]);
      wr({1'b1, r.op[4], 8'h10}, r.v[55:48]);
      run(r.op, r.v[39:32], cyc, sk);
      chk("skip", 16'(sk), 16'(r.v[0]));
      chk("cycles", 16'(cyc), r.v[0] ? 16'd3 : 16'd2);
      rd({2'b00, REG_ACC}, d);
      chk("acc", 16'(d), 16'(r.v[31:24]));
      rd({1'b1, r.op[4], 8'h10}, d);
      chk("mem", 16'(d), 16'(r.v[23:16]));
      rd({2'b00, REG_STATUS}, d);
      chk("status", 16'(d), 16'(r.v[15:8]));
    end
    wr({2'b00, REG_ACC}, 8'h10);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op_subtract_imm;
    cmd_imm <= 8'h01;
    repeat (4) @(posedge ref_clk);
    cmd_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd({2'b00, REG_ACC}, d);
    chk("acc_b2b", 16'(d), 16'h000E);
    wr({2'b00, REG_TABLE_POINTER_LOW}, 8'hFE);
    wr({2'b00, REG_TABLE_POINTER_HIGH}, 8'h03);
    wr({2'b00, REG_STATUS}, 8'h3F);
    tp = 8'hFE;
    for (int k = 0; k < 4; k++) begin
      if (k > 1) begin
        tp = tp + 8'h01;
      end
      pa = k[0] ? {4'hF, tp} : {4'h3, tp};
      run(tops[k], 8'h00, cyc, sk);
      chk("tbl_cycles", 16'(cyc), 16'd4);
      chk("prog_addr", 16'(prog_addr), 16'(pa));
      rd({1'b1, 1'b0, 8'h10}, d);
      chk("tbl_low", 16'(d), 16'(pa[7:0]));
      rd({2'b00, REG_TABLE_HIGH_BYTE}, d);
      chk("tbl_high", 16'(d), {12'h00A, pa[11:8]});
      rd({2'b00, REG_TABLE_POINTER_LOW}, d);
      chk("table_pointer_low", 16'(d), 16'(tp));
    end
    rd({2'b00, REG_STATUS}, d);
    chk("tbl_status", 16'(d), 16'h003F);
    wr({2'b00, REG_SECT}, 8'h01);
    wr({1'b1, 1'b1, 8'h10}, 8'h12);
    run(op_nibble_exchange, 8'h00, cyc, sk);
    rd({1'b1, 1'b1, 8'h10}, d);
    chk("sect_mem", 16'(d), 16'h0021);
    rd({2'b00, REG_SECT}, d);
    chk("sect", 16'(d), 16'h0001);
    // Second reset in mid run
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd({2'b00, 8'(i)}, d);
      chk("reset_mid", 16'(d), 16'h0000);
    end
    rd({1'b1, 1'b1, 8'h10}, d);
    chk("reset_mem", 16'(d), 16'h0000);
    report_and_stop();
  end
endmodule

bind ixe_core ixe_core_sva #(.PROG_AW(PROG_AW)) u_sva (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
  .cmd_op(cmd_op), .busy(busy), .done(done), .skipped(skipped),
  .prog_addr(prog_addr), .prog_rd(prog_rd));

`default_nettype wire
